// File: ilo_core.sv
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - Low access operands offset from frame pointer
// - Indexed add: accumulator plus byte at pointer+offset
// - Add decoded from 0010 01d0 kkkk kkkk
// - d=0 to accumulator, d=1 to memory
// - Add updates N, OV, C, DC, Z
// - Bit-set indexed sets bit b, flags kept; code decodes b=3 (upper byte 86h) as fill instead
// - Fill indexed writes FFh, flags kept
// - One word, one cycle of four quarters
// - Extension enable resets to one
// - Disabled: access bank or bank-selected literal
// - Remap only when access select is zero
module ilo_core
	import ilo_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	output logic instr_ready,
	output logic instr_done,
	output logic [11:0] mem_addr,
	input wire logic [7:0] mem_rd_data,
	output logic mem_wr_en,
	output logic [7:0] mem_wr_data
);
	// ==========================================
	// Decode
	function automatic ilo_op_e ilo_decode(input logic [15:0] w);
		ilo_op_e op;
		op = ILO_OP_NONE;
		if (w[15:8] == ILO_OPC_FILL) begin
			op = ILO_OP_FILL;
		end else if (w[15:12] == ILO_OPC_BSET) begin
			op = ILO_OP_BSET;
		end else if (w[15:10] == ILO_OPC_ADD) begin
			op = ILO_OP_ADD;
		end
		return op;
	endfunction : ilo_decode

	logic ext_enable_reg;
	logic [11:0] sfp_reg;
	logic [3:0] bank_reg;
	logic [7:0] acc_reg;
	logic [4:0] flags_reg;
	logic [15:0] count_reg;
	ilo_q_e q_reg;
	ilo_op_e op_reg;
	logic busy_reg;
	logic dest_mem_reg;
	logic [2:0] bit_reg;
	logic [7:0] operand_reg;
	logic [7:0] result_reg;
	logic [4:0] flags_next;
	logic [8:0] sum;
	logic [4:0] nib_sum;
	logic [11:0] eff_addr;
	logic apb_wr;
	logic apb_hit;
	logic exec_q4;

	// ==========================================
	// Address generation
	ilo_addr_gen u_addr (
		.ext_enable(ext_enable_reg),
		.access_sel(instr_word[ILO_OP_A_BIT]),
		.operand(instr_word[7:0]),
		.stack_frame_pointer(sfp_reg),
		.bank_select_register(bank_reg),
		.eff_addr(eff_addr),
		.indexed()
	);

	// ==========================================
	// Quarter sequencer
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			q_reg <= ILO_Q1;
		end else begin
			case (q_reg)
				ILO_Q1: q_reg <= ILO_Q2;
				ILO_Q2: q_reg <= ILO_Q3;
				ILO_Q3: q_reg <= ILO_Q4;
				ILO_Q4: q_reg <= ILO_Q1;
				default: q_reg <= ILO_Q1;
			endcase
		end
	end

	// Fetch only accepts a word at Q1 so each word gets one full cycle
	assign instr_ready = (q_reg == ILO_Q1);
	assign exec_q4 = (q_reg == ILO_Q4) && busy_reg;
	assign instr_done = exec_q4;
	assign mem_wr_en = exec_q4 && dest_mem_reg;

	// Q1: decode and latch operand address
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			busy_reg <= 1'b0;
			op_reg <= ILO_OP_NONE;
			dest_mem_reg <= 1'b0;
			bit_reg <= 3'h0;
			mem_addr <= 12'h000;
		end else if (q_reg == ILO_Q1) begin
			busy_reg <= instr_valid;
			op_reg <= instr_valid ? ilo_decode(instr_word) : ILO_OP_NONE;
			bit_reg <= instr_word[11:9];
			mem_addr <= eff_addr;
			if (ilo_decode(instr_word) == ILO_OP_ADD) begin
				dest_mem_reg <= instr_word[ILO_OP_D_BIT];
			end else begin
				dest_mem_reg <= (ilo_decode(instr_word) != ILO_OP_NONE);
			end
		end
	end

	// Q2: operand read, memory answers combinationally
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			operand_reg <= 8'h00;
		end else if (q_reg == ILO_Q2) begin
			operand_reg <= mem_rd_data;
		end
	end

	// ==========================================
	// Q3: process
	always_comb begin
		sum = {1'b0, acc_reg} + {1'b0, operand_reg};
		nib_sum = {1'b0, acc_reg[3:0]} + {1'b0, operand_reg[3:0]};
		flags_next = flags_reg;
		flags_next[ILO_FLAG_C] = sum[8];
		flags_next[ILO_FLAG_DC] = nib_sum[4];
		flags_next[ILO_FLAG_Z] = (sum[7:0] == 8'h00);
		flags_next[ILO_FLAG_N] = sum[7];
		flags_next[ILO_FLAG_OV] = (acc_reg[7] == operand_reg[7]) && (sum[7] != acc_reg[7]);
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			result_reg <= 8'h00;
		end else if (q_reg == ILO_Q3) begin
			case (op_reg)
				ILO_OP_ADD: result_reg <= sum[7:0];
				ILO_OP_BSET: result_reg <= operand_reg | (8'h01 << bit_reg);
				ILO_OP_FILL: result_reg <= ILO_FILL_VALUE;
				default: result_reg <= operand_reg;
			endcase
		end
	end

	assign mem_wr_data = result_reg;

	// ==========================================
	// APB slave, zero wait states
	assign pready = 1'b1;
	assign apb_hit = (paddr == ILO_OFF_CTRL) || (paddr == ILO_OFF_SFP) ||
		(paddr == ILO_OFF_BANK) || (paddr == ILO_OFF_ACC) ||
		(paddr == ILO_OFF_FLAGS) || (paddr == ILO_OFF_COUNT);
	assign pslverr = psel && penable && !apb_hit;
	assign apb_wr = psel && penable && pwrite;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ext_enable_reg <= ILO_RST_EXT_ENABLE;
			sfp_reg <= ILO_RST_SFP;
			bank_reg <= ILO_RST_BANK;
		end else if (apb_wr) begin
			if (paddr == ILO_OFF_CTRL) begin
				ext_enable_reg <= pwdata[ILO_CTRL_EXT_BIT];
			end
			if (paddr == ILO_OFF_SFP) begin
				sfp_reg <= pwdata[11:0];
			end
			if (paddr == ILO_OFF_BANK) begin
				bank_reg <= pwdata[3:0];
			end
		end
	end

	// Execution at Q4 wins over a software write in the same cycle
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			acc_reg <= ILO_RST_ACC;
		end else if (exec_q4 && (op_reg == ILO_OP_ADD) && !dest_mem_reg) begin
			acc_reg <= result_reg;
		end else if (apb_wr && (paddr == ILO_OFF_ACC)) begin
			acc_reg <= pwdata[7:0];
		end
	end

	// Flags are computed at Q3 from live operands, committed at Q4
	logic [4:0] flags_hold;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			flags_hold <= ILO_RST_FLAGS;
		end else if (q_reg == ILO_Q3) begin
			flags_hold <= flags_next;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			flags_reg <= ILO_RST_FLAGS;
		end else if (exec_q4 && (op_reg == ILO_OP_ADD)) begin
			flags_reg <= flags_hold;
		end else if (apb_wr && (paddr == ILO_OFF_FLAGS)) begin
			flags_reg <= pwdata[4:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			count_reg <= ILO_RST_COUNT;
		end else if (exec_q4 && (op_reg != ILO_OP_NONE)) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				ILO_OFF_CTRL: prdata <= {31'h0, ext_enable_reg};
				ILO_OFF_SFP: prdata <= {20'h0, sfp_reg};
				ILO_OFF_BANK: prdata <= {28'h0, bank_reg};
				ILO_OFF_ACC: prdata <= {24'h0, acc_reg};
				ILO_OFF_FLAGS: prdata <= {27'h0, flags_reg};
				ILO_OFF_COUNT: prdata <= {16'h0, count_reg};
				default: prdata <= 32'h00000000;
			endcase
		end
	end
endmodule : ilo_core

// File: ilo_pkg.sv
package ilo_pkg;
	// ==========================================
	// Register map (APB byte addresses)
	localparam logic [7:0] ILO_OFF_CTRL = 8'h00;
	localparam logic [7:0] ILO_OFF_SFP = 8'h04;
	localparam logic [7:0] ILO_OFF_BANK = 8'h08;
	localparam logic [7:0] ILO_OFF_ACC = 8'h0C;
	localparam logic [7:0] ILO_OFF_FLAGS = 8'h10;
	localparam logic [7:0] ILO_OFF_COUNT = 8'h14;

	// ==========================================
	// Field positions
	localparam int ILO_CTRL_EXT_BIT = 0;
	localparam int ILO_FLAG_C = 0;
	localparam int ILO_FLAG_DC = 1;
	localparam int ILO_FLAG_Z = 2;
	localparam int ILO_FLAG_OV = 3;
	localparam int ILO_FLAG_N = 4;
	localparam int ILO_OP_A_BIT = 8;
	localparam int ILO_OP_D_BIT = 9;

	// ==========================================
	// Reset values
	localparam logic ILO_RST_EXT_ENABLE = 1'b1;
	localparam logic [11:0] ILO_RST_SFP = 12'h000;
	localparam logic [3:0] ILO_RST_BANK = 4'h0;
	localparam logic [7:0] ILO_RST_ACC = 8'h00;
	localparam logic [4:0] ILO_RST_FLAGS = 5'h00;
	localparam logic [15:0] ILO_RST_COUNT = 16'h0000;

	// ==========================================
	// Operand decode constants
	localparam logic [7:0] ILO_INDEX_MAX = 8'h5F;
	localparam logic [7:0] ILO_ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] ILO_ACCESS_HI_BANK = 4'hF;
	localparam logic [7:0] ILO_FILL_VALUE = 8'hFF;

	// ==========================================
	// Opcode patterns on the upper byte
	localparam logic [5:0] ILO_OPC_ADD = 6'h09;
	localparam logic [7:0] ILO_OPC_FILL = 8'h86;
	localparam logic [3:0] ILO_OPC_BSET = 4'h8;

	typedef enum logic [1:0] {
		ILO_OP_NONE,
		ILO_OP_ADD,
		ILO_OP_BSET,
		ILO_OP_FILL
	} ilo_op_e;

	typedef enum logic [1:0] {
		ILO_Q1,
		ILO_Q2,
		ILO_Q3,
		ILO_Q4
	} ilo_q_e;
endpackage : ilo_pkg

// File: ilo_addr_gen.sv
`timescale 1ns/1ps
module ilo_addr_gen
	import ilo_pkg::*;
(
	input wire logic ext_enable,
	input wire logic access_sel,
	input wire logic [7:0] operand,
	input wire logic [11:0] stack_frame_pointer,
	input wire logic [3:0] bank_select_register,
	output logic [11:0] eff_addr,
	output logic indexed
);
	// ==========================================
	// Operand to data address
	always_comb begin
		indexed = ext_enable && !access_sel && (operand <= ILO_INDEX_MAX);
		if (indexed) begin
			// Pointer is only read here, never modified
			eff_addr = stack_frame_pointer + {4'h0, operand};
		end else if (access_sel) begin
			eff_addr = {bank_select_register, operand};
		end else if (operand < ILO_ACCESS_SPLIT) begin
			eff_addr = {4'h0, operand};
		end else begin
			eff_addr = {ILO_ACCESS_HI_BANK, operand};
		end
	end
endmodule : ilo_addr_gen

// File: ilo_core_monitor.sv
`timescale 1ns/1ps
// ====
// Port checker
module ilo_core_monitor
	import ilo_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic instr_done,
	input wire logic [15:0] instr_word,
	input wire logic [11:0] mem_addr,
	input wire logic [7:0] mem_rd_data,
	input wire logic mem_wr_en,
	input wire logic [7:0] mem_wr_data
);
	logic ext_reg;
	logic [11:0] sfp_reg, ea;
	logic [3:0] bank_reg;
	logic [7:0] bm;
	logic tk, bs;
	assign tk = instr_ready && instr_valid;
	assign bs = instr_word[15:12] == 4'h8 && instr_word[11:8] != 4'h6;
	assign ea = sfp_reg + {4'h0, instr_word[7:0]};
	assign bm = 8'h01 << instr_word[11:9];
	// Shadow copy, so address checks need no peek inside
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ext_reg <= ILO_RST_EXT_ENABLE;
			sfp_reg <= ILO_RST_SFP;
			bank_reg <= ILO_RST_BANK;
		end else if (psel && penable && pwrite && pready) begin
			case (paddr)
				ILO_OFF_CTRL: ext_reg <= pwdata[ILO_CTRL_EXT_BIT];
				ILO_OFF_SFP: sfp_reg <= pwdata[11:0];
				ILO_OFF_BANK: bank_reg <= pwdata[3:0];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	a_quarter_ring: assert property (instr_ready |=> !instr_ready [*3] ##1 instr_ready)
		else $error("ready not one cycle in four");
	a_done_slot: assert property (tk |-> ##3 instr_done)
		else $error("done late");
	a_wr_in_q4: assert property (mem_wr_en |-> instr_done)
		else $error("write outside Q4");
	a_addr_hold: assert property (tk |=> ##1 $stable(mem_addr) [*2])
		else $error("address moved");
	a_index_addr: assert property (tk && ext_reg && !instr_word[8] &&
		instr_word[7:0] <= ILO_INDEX_MAX |=> mem_addr == $past(ea))
		else $error("indexed address wrong");
	a_bank_addr: assert property (tk && instr_word[8] |=>
		mem_addr == $past({bank_reg, instr_word[7:0]}))
		else $error("banked address wrong");
	a_fill_ones: assert property (tk && instr_word[15:8] == 8'h86 |->
		##3 mem_wr_en && mem_wr_data == ILO_FILL_VALUE)
		else $error("fill data wrong");
	a_bit_set: assert property (tk && bs |=> ##2 mem_wr_en &&
		mem_wr_data == ($past(mem_rd_data, 2) | $past(bm, 3)))
		else $error("bit set data wrong");
	c_add: cover property (tk && instr_word[15:10] == 6'h09);
	c_fill: cover property (tk && instr_word[15:8] == 8'h86);
	c_wr: cover property (mem_wr_en ##4 mem_wr_en);
endmodule : ilo_core_monitor

// File: ilo_mem_model.sv
`timescale 1ns/1ps
// ====
// Data memory, answers at once
module ilo_mem_model (
	input wire logic ref_clk,
	input wire logic [11:0] mem_addr,
	input wire logic mem_wr_en,
	input wire logic [7:0] mem_wr_data,
	output logic [7:0] mem_rd_data
);
	logic [7:0] m [4096];
	initial begin
		for (int i = 0; i < 4096; i++) begin
			m[i] = 8'h00;
		end
	end
	assign mem_rd_data = m[mem_addr];
	always @(posedge ref_clk) begin
		if (mem_wr_en) begin
			m[mem_addr] <= mem_wr_data;
		end
	end
endmodule : ilo_mem_model

// File: tb_indexed_literal_offset_decode.sv
`timescale 1ns/1ps
// ====
// Bench
module tb_indexed_literal_offset_decode
	import ilo_pkg::*;
;
	logic ref_clk, reset, psel, penable, pwrite, pready, pslverr;
	logic instr_valid, instr_ready, instr_done, mem_wr_en;
	logic [7:0] paddr, mem_rd_data, mem_wr_data;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] instr_word;
	logic [11:0] mem_addr;
	int err_total, compares;
	logic slv_err;
	ilo_core dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
		.instr_ready(instr_ready), .instr_done(instr_done), .mem_addr(mem_addr),
		.mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data));
	ilo_mem_model mem (.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_wr_en(mem_wr_en),
		.mem_wr_data(mem_wr_data), .mem_rd_data(mem_rd_data));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = prdata;
		slv_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Extra cycle at the end lets the Q4 write land before any check
	task exec(input logic [15:0] w);
		@(posedge ref_clk);
		instr_valid <= 1'b1;
		instr_word <= w;
		do @(negedge ref_clk); while (instr_ready !== 1'b1);
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		repeat (3) @(negedge ref_clk);
		chk({31'h0, instr_done}, 32'h1);
		@(negedge ref_clk);
	endtask : exec
	task t_add;
		apb(1'b1, ILO_OFF_SFP, 32'hA00, rd);
		apb(1'b1, ILO_OFF_ACC, 32'h17, rd);
		mem.m[12'hA2C] = 8'h20;
		exec(16'h242C);
		apb(1'b0, ILO_OFF_ACC, 32'h0, rd);
		chk(rd, 32'h37);
		apb(1'b0, ILO_OFF_FLAGS, 32'h0, rd);
		chk(rd, 32'h00);
		apb(1'b1, ILO_OFF_ACC, 32'hF8, rd);
		mem.m[12'hA2D] = 8'h08;
		exec(16'h262D);
		chk({24'h0, mem.m[12'hA2D]}, 32'h00);
		apb(1'b0, ILO_OFF_ACC, 32'h0, rd);
		chk(rd, 32'hF8);
		apb(1'b0, ILO_OFF_FLAGS, 32'h0, rd);
		chk(rd, 32'h07);
		apb(1'b0, ILO_OFF_SFP, 32'h0, rd);
		chk(rd, 32'hA00);
		// Signed overflow into bit 7 sets N, OV and DC together
		apb(1'b1, ILO_OFF_ACC, 32'h7F, rd);
		mem.m[12'hA30] = 8'h01;
		exec(16'h2430);
		apb(1'b0, ILO_OFF_ACC, 32'h0, rd);
		chk(rd, 32'h80);
		chk({24'h0, mem.m[12'hA30]}, 32'h01);
		apb(1'b0, ILO_OFF_FLAGS, 32'h0, rd);
		chk(rd, 32'h1A);
	endtask : t_add
	task t_bits;
		mem.m[12'hA0A] = 8'h55;
		exec(16'h8E0A);
		chk({24'h0, mem.m[12'hA0A]}, 32'hD5);
		for (int i = 0; i < 8; i++) begin
			if (i != 3) begin
				exec({4'h8, i[2:0], 1'b0, 8'h5F});
			end
		end
		chk({24'h0, mem.m[12'hA5F]}, 32'hF7);
		// Fresh zero byte, so a bit-set of bit 3 could not pass as fill
		exec(16'h862E);
		chk({24'h0, mem.m[12'hA2E]}, 32'hFF);
		apb(1'b0, ILO_OFF_FLAGS, 32'h0, rd);
		chk(rd, 32'h1A);
		apb(1'b0, ILO_OFF_COUNT, 32'h0, rd);
		chk(rd, 32'h11);
	endtask : t_bits
	task t_modes;
		apb(1'b0, ILO_OFF_CTRL, 32'h0, rd);
		chk(rd, 32'h1);
		apb(1'b0, 8'h18, 32'h0, rd);
		chk(rd, 32'h0);
		chk({31'h0, slv_err}, 32'h1);
		// Nonzero pointer so remapped and literal addresses differ
		apb(1'b1, ILO_OFF_SFP, 32'h200, rd);
		exec(16'h805F);
		chk({24'h0, mem.m[12'h25F]}, 32'h01);
		exec(16'h8060);
		chk({24'h0, mem.m[12'h060]}, 32'h01);
		apb(1'b1, ILO_OFF_BANK, 32'h3, rd);
		exec(16'h8110);
		chk({24'h0, mem.m[12'h310]}, 32'h01);
		apb(1'b1, ILO_OFF_CTRL, 32'h0, rd);
		exec(16'h802C);
		chk({24'h0, mem.m[12'h02C]}, 32'h01);
		exec(16'h8090);
		chk({24'h0, mem.m[12'hF90]}, 32'h01);
		apb(1'b1, ILO_OFF_CTRL, 32'h1, rd);
	endtask : t_modes
	task summarize;
		$display("err_total=%0d compares=%0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		#100000;
		err_total++;
		summarize;
	end
	initial begin
		{reset, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h00, 32'h0};
		{instr_valid, instr_word, err_total, compares} = '0;
		repeat (12) @(posedge ref_clk);
		reset <= 1'b0;
		t_modes;
		t_add;
		t_bits;
		summarize;
	end
endmodule : tb_indexed_literal_offset_decode
bind ilo_core ilo_core_monitor u_mon (.ref_clk(ref_clk), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
	.instr_valid(instr_valid), .instr_ready(instr_ready), .instr_done(instr_done),
	.instr_word(instr_word), .mem_addr(mem_addr), .mem_rd_data(mem_rd_data),
	.mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data));
